// *** common/flash_pkg.sv ***
package flash_pkg;
	// -------------------------------------------------------------
	// Serial command set and array layout
	// -------------------------------------------------------------
	localparam logic [7:0] OP_PROGRAM       = 8'h02;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS   = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] ERASED_BYTE      = 8'hff;
	localparam int         PAGE_BYTES       = 256;
	localparam int         SECTOR_LSB       = 16;
	localparam int         OPCODE_BITS      = 8;
	localparam int         ADDR_BITS        = 24;
	// Byte and bit counter values within a frame
	localparam logic [2:0] OPCODE_BYTE      = 3'h0;
	localparam logic [2:0] LAST_ADDR_BYTE   = 3'h3;
	localparam logic [2:0] FIRST_DATA_BYTE  = 3'h4;
	localparam logic [2:0] ONE_DATA_BYTE    = 3'h5;
	localparam logic [2:0] LAST_BIT         = 3'h7;
	// Device status byte layout
	localparam int         ST_BUSY_BIT      = 0;
	localparam int         ST_WEL_BIT       = 1;
	localparam int         ST_EPE_BIT       = 5;
	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS         = 5;
	localparam int PAGE_PROGRAM_TIME_US  = 1000;
	localparam int BYTE_PROGRAM_TIME_US  = 50;
	localparam int PP_CYCLES = PAGE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int BP_CYCLES = BYTE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int SCK_HALF_CYCLES       = 8;
	// -------------------------------------------------------------
	// Controller register map
	// -------------------------------------------------------------
	localparam logic [7:0]  REG_CMD        = 8'h00;
	localparam logic [7:0]  REG_ADDR       = 8'h04;
	localparam logic [7:0]  REG_DATA       = 8'h08;
	localparam logic [7:0]  REG_STATUS     = 8'h0c;
	localparam logic [7:0]  REG_IRQ_STATUS = 8'h10;
	localparam logic [7:0]  REG_IRQ_MASK   = 8'h14;
	localparam logic [31:0] CMD_MASK       = 32'h003fffff;
	localparam logic [31:0] ADDR_MASK      = 32'h00ffffff;
	localparam int          CMD_ADDR_BIT   = 8;
	localparam int          CMD_COUNT_LSB  = 9;
	localparam int          CMD_EXTRA_LSB  = 19;
	localparam int          STATUS_RX_LSB  = 8;
	localparam int          IRQ_DONE_BIT   = 0;
	localparam int          IRQ_ERR_BIT    = 1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// *** common/flash_link_if.sv ***
`timescale 1ns/10ps
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;

	// Pulled high while the device leaves the pin undriven
	assign so_line = so_oe ? so : 1'b1;

	modport device (input sck, input cs_n, input si, output so, output so_oe);
	modport host (output sck, output cs_n, output si, input so_line);
endinterface

// *** design/flash_program_device.sv ***
`timescale 1ns/10ps
module flash_program_device #(
	parameter int ARRAY_AW  = 9,
	parameter int SECT_W    = 2,
	parameter int PP_CYCLES = flash_pkg::PP_CYCLES,
	parameter int BP_CYCLES = flash_pkg::BP_CYCLES
) (
	input  wire logic                   CLK,                // System clock
	input  wire logic                   RESET_N,            // Async reset
	flash_link_if.device                LINK,               // Serial pins
	input  wire logic [2**SECT_W-1:0]   PROTECT,            // Protected or locked sectors
	input  wire logic [ARRAY_AW-1:0]    RD_ADDR,            // Array inspection address
	output logic      [7:0]             RD_DATA,            // Array inspection data
	output logic                        BUSY,               // Array write running
	output logic                        WRITE_ENABLE_LATCH, // Write enable latch
	output logic                        PROGRAM_ERROR_FLAG  // Last program failed
);
	localparam int PB = flash_pkg::PAGE_BYTES;
	localparam int AB = 2**ARRAY_AW;
	localparam int TW = $clog2(PP_CYCLES + 1);

	typedef enum logic [1:0] {ST_READY, ST_WRITE, ST_WAIT} state_e;

	typedef struct packed {
		state_e                 st;
		logic                   sck_s1, sck_s2, sck_d;
		logic                   cs_s1, cs_s2, cs_d;
		logic                   si_s1, si_s2;
		logic [2:0]             bitc;
		logic [2:0]             bytec;
		logic [7:0]             shift;
		logic [7:0]             opcode;
		logic [7:0]             tx;
		logic [7:0]             woff;
		logic [23:0]            addr;
		logic                   so, so_oe;
		logic                   write_enable_latch, program_error_flag;
		logic [TW-1:0]          timer;
		logic [7:0]             idx;
		logic [PB-1:0]          loaded;
		logic [PB-1:0][7:0]     pbuf;
		logic [AB-1:0][7:0]     mem;
		logic [7:0]             rd_data;
	} state_s;

	state_s                s;
	state_s                next_s;
	logic                  sck_rise;
	logic                  sck_fall;
	logic                  cs_rel;
	logic [7:0]            nb;
	logic [7:0]            status;
	logic [7:0]            v;
	logic [ARRAY_AW-1:0]   pa;
	logic                  prot;

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.sck_s1 = LINK.sck;
		next_s.sck_s2 = s.sck_s1;
		next_s.sck_d  = s.sck_s2;
		next_s.cs_s1  = LINK.cs_n;
		next_s.cs_s2  = s.cs_s1;
		next_s.cs_d   = s.cs_s2;
		next_s.si_s1  = LINK.si;
		next_s.si_s2  = s.si_s1;
		next_s.rd_data = s.mem[RD_ADDR];

		sck_rise = s.sck_s2 & ~s.sck_d;
		sck_fall = ~s.sck_s2 & s.sck_d;
		cs_rel   = s.cs_s2 & ~s.cs_d;
		nb       = {s.shift[6:0], s.si_s2};
		prot     = PROTECT[s.addr[flash_pkg::SECTOR_LSB +: SECT_W]];
		pa       = {s.addr[ARRAY_AW-1:8], s.idx};
		v        = s.mem[pa] & s.pbuf[s.idx];

		status = 8'h00;
		status[flash_pkg::ST_BUSY_BIT] = (s.st != ST_READY);
		status[flash_pkg::ST_WEL_BIT]  = s.write_enable_latch;
		status[flash_pkg::ST_EPE_BIT]  = s.program_error_flag;

		// Serial frame decode
		if (s.cs_s2) begin
			next_s.bitc  = 3'h0;
			next_s.bytec = flash_pkg::OPCODE_BYTE;
			next_s.so_oe = 1'b0;
		end else if (sck_rise) begin
			next_s.bitc  = s.bitc + 3'h1;
			next_s.shift = nb;
			if (s.bitc == flash_pkg::LAST_BIT) begin
				if (s.bytec != 3'h7) begin
					next_s.bytec = s.bytec + 3'h1;
				end
				if (s.bytec == flash_pkg::OPCODE_BYTE) begin
					next_s.opcode = nb;
					next_s.tx     = status;
					if (nb == flash_pkg::OP_PROGRAM && s.st == ST_READY) begin
						next_s.loaded = '0;
					end
				end else if (s.opcode == flash_pkg::OP_READ_STATUS) begin
					next_s.tx = status;
				end else if (s.opcode == flash_pkg::OP_PROGRAM && s.st == ST_READY) begin
					if (s.bytec < flash_pkg::FIRST_DATA_BYTE) begin
						next_s.addr = {s.addr[15:0], nb};
						if (s.bytec == flash_pkg::LAST_ADDR_BYTE) begin
							next_s.woff = nb;
						end
					end else begin
						// Offset wraps in the page; newer bytes overwrite
						next_s.pbuf[s.woff]   = nb;
						next_s.loaded[s.woff] = 1'b1;
						next_s.woff           = s.woff + 8'h01;
					end
				end
			end
		end else if (sck_fall && s.opcode == flash_pkg::OP_READ_STATUS
			&& s.bytec != flash_pkg::OPCODE_BYTE) begin
			next_s.so    = s.tx[7];
			next_s.tx    = {s.tx[6:0], 1'b0};
			next_s.so_oe = 1'b1;
		end

		// Chip select release
		if (cs_rel && s.st == ST_READY && s.bytec != flash_pkg::OPCODE_BYTE) begin
			case (s.opcode)
				flash_pkg::OP_WRITE_ENABLE: begin
					if (s.bytec == 3'h1 && s.bitc == 3'h0) begin
						next_s.write_enable_latch = 1'b1;
					end
				end
				flash_pkg::OP_WRITE_DISABLE: begin
					if (s.bytec == 3'h1 && s.bitc == 3'h0) begin
						next_s.write_enable_latch = 1'b0;
					end
				end
				flash_pkg::OP_PROGRAM: begin
					if (s.write_enable_latch) begin
						next_s.write_enable_latch = 1'b0;
						if (s.bytec >= flash_pkg::ONE_DATA_BYTE && s.bitc == 3'h0
							&& !prot) begin
							next_s.st    = ST_WRITE;
							next_s.idx   = 8'h00;
							next_s.program_error_flag   = 1'b0;
							next_s.timer = (s.bytec == flash_pkg::ONE_DATA_BYTE)
								? TW'(BP_CYCLES) : TW'(PP_CYCLES);
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Self-timed array write
		if (s.timer != '0) begin
			next_s.timer = s.timer - TW'(1);
		end
		case (s.st)
			ST_WRITE: begin
				if (s.loaded[s.idx]) begin
					next_s.mem[pa] = v;
					if (v != s.pbuf[s.idx]) begin
						next_s.program_error_flag = 1'b1;
					end
				end
				next_s.idx = s.idx + 8'h01;
				if (s.idx == 8'hff) begin
					next_s.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (s.timer == '0) begin
					next_s.st = ST_READY;
				end
			end
			default: begin
			end
		endcase
	end

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s        <= '0;
			s.mem    <= '1;
			s.pbuf   <= '1;
			s.cs_s1  <= 1'b1;
			s.cs_s2  <= 1'b1;
			s.cs_d   <= 1'b1;
			s.st     <= ST_READY;
		end else begin
			s <= next_s;
		end
	end

	assign LINK.so            = s.so;
	assign LINK.so_oe         = s.so_oe;
	assign RD_DATA            = s.rd_data;
	assign BUSY               = (s.st != ST_READY);
	assign WRITE_ENABLE_LATCH = s.write_enable_latch;
	assign PROGRAM_ERROR_FLAG = s.program_error_flag;
endmodule // flash_program_device

// *** design/flash_program_host.sv ***
`timescale 1ns/10ps
module flash_program_host #(
	parameter int SCK_HALF = flash_pkg::SCK_HALF_CYCLES
) (
	input  wire logic        CLK,     // System clock
	input  wire logic        RESET_N, // Async reset
	flash_link_if.host       LINK,    // Serial pins
	input  wire logic [7:0]  AWADDR,  // Write address
	input  wire logic        AWVALID, // Write address valid
	output logic             AWREADY, // Write address ready
	input  wire logic [31:0] WDATA,   // Write data
	input  wire logic [3:0]  WSTRB,   // Write strobes
	input  wire logic        WVALID,  // Write data valid
	output logic             WREADY,  // Write data ready
	output logic [1:0]       BRESP,   // Write response
	output logic             BVALID,  // Write response valid
	input  wire logic        BREADY,  // Write response ready
	input  wire logic [7:0]  ARADDR,  // Read address
	input  wire logic        ARVALID, // Read address valid
	output logic             ARREADY, // Read address ready
	output logic [31:0]      RDATA,   // Read data
	output logic [1:0]       RRESP,   // Read response
	output logic             RVALID,  // Read data valid
	input  wire logic        RREADY,  // Read data ready
	output logic             IRQ      // Level interrupt
);
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_END, H_GAP} hstate_e;

	typedef struct packed {
		hstate_e      st;
		logic         aw_ok, w_ok, bvalid, rvalid;
		logic [7:0]   awaddr;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic [1:0]   bresp, rresp;
		logic [31:0]  rdata;
		logic [31:0]  cmd, addr, pattern;
		logic [1:0]   irq_st, irq_mask;
		logic [7:0]   rx;
		logic [7:0]   div;
		logic [13:0]  bit_i;
		logic         sck, cs_n, si;
		logic         so_s1, so_s2;
	} hstate_s;

	hstate_s      s;
	hstate_s      next_s;
	logic [1:0]   clr;
	logic [1:0]   set;
	logic         start;
	logic         use_addr;
	logic [13:0]  total;
	logic [13:0]  q;
	logic [13:0]  dk;
	logic         out_bit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = val[8*i +: 8];
			end
		end
	endfunction

	// -------------------------------------------------------------
	// Register slave and frame engine
	// -------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.so_s1 = LINK.so_line;
		next_s.so_s2 = s.so_s1;
		clr   = 2'h0;
		set   = 2'h0;
		start = 1'b0;

		if (AWVALID && AWREADY) begin
			next_s.aw_ok  = 1'b1;
			next_s.awaddr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_s.w_ok  = 1'b1;
			next_s.wdata = WDATA;
			next_s.wstrb = WSTRB;
		end
		if (BREADY && s.bvalid) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			next_s.aw_ok  = 1'b0;
			next_s.w_ok   = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = flash_pkg::RESP_OKAY;
			case (s.awaddr)
				flash_pkg::REG_CMD: begin
					if (s.st == H_IDLE) begin
						next_s.cmd = merge(s.cmd, s.wdata, s.wstrb) & flash_pkg::CMD_MASK;
						start      = 1'b1;
					end
				end
				flash_pkg::REG_ADDR: begin
					next_s.addr = merge(s.addr, s.wdata, s.wstrb) & flash_pkg::ADDR_MASK;
				end
				flash_pkg::REG_DATA: begin
					next_s.pattern = merge(s.pattern, s.wdata, s.wstrb);
				end
				flash_pkg::REG_IRQ_STATUS: begin
					clr = s.wstrb[0] ? s.wdata[1:0] : 2'h0;
				end
				flash_pkg::REG_IRQ_MASK: begin
					if (s.wstrb[0]) begin
						next_s.irq_mask = s.wdata[1:0];
					end
				end
				default: begin
					next_s.bresp = flash_pkg::RESP_SLVERR;
				end
			endcase
		end

		if (RREADY && s.rvalid) begin
			next_s.rvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = flash_pkg::RESP_OKAY;
			next_s.rdata  = 32'h0;
			case (ARADDR)
				flash_pkg::REG_CMD:        next_s.rdata = s.cmd;
				flash_pkg::REG_ADDR:       next_s.rdata = s.addr;
				flash_pkg::REG_DATA:       next_s.rdata = s.pattern;
				flash_pkg::REG_STATUS: begin
					next_s.rdata[0] = (s.st != H_IDLE);
					next_s.rdata[flash_pkg::STATUS_RX_LSB +: 8] = s.rx;
				end
				flash_pkg::REG_IRQ_STATUS: next_s.rdata[1:0] = s.irq_st;
				flash_pkg::REG_IRQ_MASK:   next_s.rdata[1:0] = s.irq_mask;
				default:                   next_s.rresp = flash_pkg::RESP_SLVERR;
			endcase
		end

		// Bit to present next, from the freshest command fields
		use_addr = next_s.cmd[flash_pkg::CMD_ADDR_BIT];
		total = 14'(flash_pkg::OPCODE_BITS)
			+ (use_addr ? 14'(flash_pkg::ADDR_BITS) : 14'h0)
			+ {1'b0, next_s.cmd[flash_pkg::CMD_COUNT_LSB +: 10], 3'h0}
			+ {11'h0, next_s.cmd[flash_pkg::CMD_EXTRA_LSB +: 3]};
		q  = (s.st == H_IDLE) ? 14'h0 : s.bit_i + 14'h1;
		dk = q - (use_addr ? 14'(flash_pkg::OPCODE_BITS + flash_pkg::ADDR_BITS)
			: 14'(flash_pkg::OPCODE_BITS));
		if (q < 14'(flash_pkg::OPCODE_BITS)) begin
			out_bit = next_s.cmd[3'h7 - q[2:0]];
		end else if (use_addr && q < 14'(flash_pkg::OPCODE_BITS + flash_pkg::ADDR_BITS)) begin
			out_bit = next_s.addr[5'h1f - q[4:0]];
		end else begin
			out_bit = next_s.pattern[5'h1f - dk[4:0]];
		end

		if (s.div != 8'h0) begin
			next_s.div = s.div - 8'h1;
		end
		case (s.st)
			H_IDLE: begin
				if (start) begin
					next_s.cs_n  = 1'b0;
					next_s.si    = out_bit;
					next_s.bit_i = 14'h0;
					next_s.div   = 8'(SCK_HALF - 1);
					next_s.st    = H_LOW;
				end
			end
			H_LOW: begin
				if (s.div == 8'h0) begin
					next_s.sck = 1'b1;
					next_s.rx  = {s.rx[6:0], s.so_s2};
					next_s.div = 8'(SCK_HALF - 1);
					next_s.st  = H_HIGH;
				end
			end
			H_HIGH: begin
				if (s.div == 8'h0) begin
					next_s.sck   = 1'b0;
					next_s.bit_i = q;
					next_s.div   = 8'(SCK_HALF - 1);
					next_s.si    = out_bit;
					next_s.st    = (q == total) ? H_END : H_LOW;
				end
			end
			H_END: begin
				if (s.div == 8'h0) begin
					next_s.cs_n = 1'b1;
					next_s.div  = 8'(SCK_HALF - 1);
					next_s.st   = H_GAP;
					set[flash_pkg::IRQ_DONE_BIT] = 1'b1;
					set[flash_pkg::IRQ_ERR_BIT]  =
						(s.cmd[7:0] == flash_pkg::OP_READ_STATUS) && s.rx[flash_pkg::ST_EPE_BIT];
				end
			end
			H_GAP: begin
				if (s.div == 8'h0) begin
					next_s.st = H_IDLE;
				end
			end
			default: begin
				next_s.st = H_IDLE;
			end
		endcase

		// Set wins over a clear in the same cycle
		next_s.irq_st = (s.irq_st & ~clr) | set;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s      <= '0;
			s.cs_n <= 1'b1;
			s.st   <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign AWREADY   = ~s.aw_ok & ~s.bvalid;
	assign WREADY    = ~s.w_ok & ~s.bvalid;
	assign BVALID    = s.bvalid;
	assign BRESP     = s.bresp;
	assign ARREADY   = ~s.rvalid;
	assign RVALID    = s.rvalid;
	assign RDATA     = s.rdata;
	assign RRESP     = s.rresp;
	assign IRQ       = |(s.irq_st & s.irq_mask);
	assign LINK.sck  = s.sck;
	assign LINK.cs_n = s.cs_n;
	assign LINK.si   = s.si;
endmodule // flash_program_host

// *** sim/flash_link_checker.sv ***
`timescale 1ns/10ps
module flash_link_checker (
	input wire logic CLK,                // System clock
	input wire logic RESET_N,            // Async reset
	input wire logic sck,                // Serial clock
	input wire logic cs_n,               // Chip select
	input wire logic si,                 // Host data
	input wire logic so_oe,              // Device drive enable
	input wire logic BUSY,               // Array write running
	input wire logic WRITE_ENABLE_LATCH, // Write enable latch
	input wire logic PROGRAM_ERROR_FLAG  // Program error
);
	// ---------------------------------------------------------
	// Busy length counter
	// ---------------------------------------------------------
	logic [11:0] busy_cnt;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			busy_cnt <= 12'h000;
		else if (BUSY)
			busy_cnt <= busy_cnt + 12'h001;
		else
			busy_cnt <= 12'h000;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	// ---------------------------------------------------------
	// Properties
	// ---------------------------------------------------------
	a_si_steady: assert property ($rose(sck) |-> $stable(si))
		else $error("si moved at sck rise");
	a_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("sck toggles outside frame");
	a_so_released: assert property (cs_n [*8] |-> !so_oe)
		else $error("so driven while deselected");
	a_start_needs_wel: assert property ($rose(BUSY) |-> $past(WRITE_ENABLE_LATCH))
		else $error("write started without latch");
	a_busy_wel_low: assert property (BUSY |-> !WRITE_ENABLE_LATCH)
		else $error("latch set while busy");
	a_start_on_release: assert property ($rose(BUSY) |-> cs_n && $past(cs_n, 2))
		else $error("write started inside frame");
	a_error_clear_start: assert property ($rose(BUSY) |-> !PROGRAM_ERROR_FLAG)
		else $error("error flag kept at start");
	a_busy_min_len: assert property ($fell(BUSY) |-> busy_cnt >= 12'd256)
		else $error("array write too short");
	a_busy_max_len: assert property (BUSY |-> busy_cnt < 12'd420)
		else $error("busy never ends");
	a_latch_at_idle: assert property ($changed(WRITE_ENABLE_LATCH) |-> cs_n)
		else $error("latch moved inside frame");
endmodule // flash_link_checker

// *** sim/testbench.sv ***
`timescale 1ns/10ps
module testbench;
	// ---------------------------------------------------------
	// Signals and design
	// ---------------------------------------------------------
	logic        clk, reset_n, busy, write_enable_latch, program_error_flag, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, rd_data, wire_op;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, prot;
	logic [1:0]  bresp, rresp;
	logic [8:0]  rd_addr;
	logic [7:0]  m_mem [512];
	logic        m_wel, m_epe, m_busy;
	int          n_fail, n_compared, cycles, wire_bits;

	flash_link_if link ();
	flash_program_host #(.SCK_HALF(6)) u_flash_program_host (.CLK(clk), .RESET_N(reset_n),
		.LINK(link), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .IRQ(irq));
	flash_program_device #(.PP_CYCLES(400), .BP_CYCLES(300)) u_flash_program_device (
		.CLK(clk), .RESET_N(reset_n), .LINK(link), .PROTECT(prot), .RD_ADDR(rd_addr),
		.RD_DATA(rd_data), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .PROGRAM_ERROR_FLAG(program_error_flag));
	flash_link_checker u_flash_link_checker (.CLK(clk), .RESET_N(reset_n), .sck(link.sck),
		.cs_n(link.cs_n), .si(link.si), .so_oe(link.so_oe), .BUSY(busy),
		.WRITE_ENABLE_LATCH(write_enable_latch), .PROGRAM_ERROR_FLAG(program_error_flag));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Wire monitor: opcode bits and frame length
	always @(negedge link.cs_n) wire_bits = 0;
	always @(posedge link.sck) if (!link.cs_n) begin
		if (wire_bits < 8) wire_op = {wire_op[6:0], link.si};
		wire_bits++;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			n_fail++;
			results();
		end
	end

	// ---------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------
	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aw_t = awvalid & awready;
			w_t = wvalid & wready;
			@(posedge clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while ((awvalid & !aw_t) | (wvalid & !w_t));
		do @(negedge clk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
		@(negedge clk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
		@(negedge clk);
	endtask

	// One serial frame through the host, then the model's view of it
	task automatic frame(input logic [7:0] op, input logic ae, input int cnt, input int ext,
			input logic [23:0] a, input logic [31:0] d, output logic [31:0] irqs);
		logic [1:0] r;
		logic [7:0] bv [256];
		bit hit [256];
		int idx;
		axi_wr(flash_pkg::REG_ADDR, {8'h00, a}, r);
		axi_wr(flash_pkg::REG_DATA, d, r);
		axi_wr(flash_pkg::REG_CMD, {10'h000, ext[2:0], cnt[9:0], ae, op}, r);
		while (irq !== 1'b1) @(negedge clk);
		axi_rd(flash_pkg::REG_IRQ_STATUS, irqs, r);
		axi_wr(flash_pkg::REG_IRQ_STATUS, 32'h3, r);
		check_val("wire_opcode", op, wire_op);
		check_val("wire_bits", 8 + 24 * ae + 8 * cnt + ext, wire_bits);
		if (!ae && cnt == 0 && ext == 0 && op == flash_pkg::OP_WRITE_ENABLE) m_wel = 1'b1;
		if (!ae && cnt == 0 && ext == 0 && op == flash_pkg::OP_WRITE_DISABLE) m_wel = 1'b0;
		if (op == flash_pkg::OP_PROGRAM && m_wel) begin
			m_wel = 1'b0;
			if (ae && cnt > 0 && ext == 0 && !prot[a[17:16]]) begin
				m_busy = 1'b1;
				m_epe = 1'b0;
				for (int k = 0; k < cnt; k++) begin
					bv[(a[7:0] + k) % 256] = d[8 * (3 - k % 4) +: 8];
					hit[(a[7:0] + k) % 256] = 1'b1;
				end
				for (int n = 0; n < 256; n++) if (hit[n]) begin
					idx = {a[8], n[7:0]};
					if ((m_mem[idx] & bv[n]) != bv[n]) m_epe = 1'b1;
					m_mem[idx] = m_mem[idx] & bv[n];
				end
			end
		end
	endtask

	task automatic status(output logic [7:0] s);
		logic [31:0] v, irqs;
		logic [1:0] r;
		frame(flash_pkg::OP_READ_STATUS, 1'b0, 1, 0, 24'h0, 32'h0, irqs);
		axi_rd(flash_pkg::REG_STATUS, v, r);
		s = v[15:8];
		if (s[0] === 1'b0) check_val("irq_error_bit", m_epe, irqs[1]);
	endtask

	task automatic check_state();
		@(negedge clk);
		check_val("busy", 0, busy);
		check_val("write_enable_latch", m_wel, write_enable_latch);
		check_val("program_error_flag", m_epe, program_error_flag);
		for (int i = 0; i < 512; i++) begin
			@(posedge clk);
			rd_addr <= i[8:0];
			@(posedge clk);
			@(negedge clk);
			check_val("array_byte", m_mem[i], rd_data);
		end
	endtask

	task automatic prog(input logic [23:0] a, input int cnt, input int ext, input logic ae,
			input logic [31:0] d);
		logic [31:0] irqs;
		logic [7:0] s;
		m_busy = 1'b0;
		frame(flash_pkg::OP_PROGRAM, ae, cnt, ext, a, d, irqs);
		if (m_busy) begin
			status(s);
			check_val("status_busy", 1, s[0]);
			check_val("status_latch", 0, s[1]);
			while (s[0] !== 1'b0) status(s);
			check_val("status_flags", {2'b00, m_epe, 3'b000, m_wel, 1'b0}, s & 8'h23);
		end
		else check_val("busy_refused", 0, busy);
		check_state();
	endtask

	task automatic cmd(input logic [7:0] op);
		logic [31:0] irqs;
		frame(op, 1'b0, 0, 0, 24'h0, 32'h0, irqs);
		@(negedge clk);
		check_val("write_enable_latch", m_wel, write_enable_latch);
	endtask

	// ---------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		{reset_n, awvalid, wvalid, bready, arvalid, rready, m_wel, m_epe} = '0;
		{awaddr, araddr, wdata, wstrb, prot, rd_addr} = '0;
		{n_fail, n_compared, cycles, wire_bits} = '0;
		wire_op = 8'h00;
		wstrb = 4'hf;
		foreach (m_mem[i]) m_mem[i] = flash_pkg::ERASED_BYTE;
		void'($urandom(32'hc259));
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		check_state();
		axi_wr(8'h20, 32'h1, r);
		check_val("bresp_unmapped", flash_pkg::RESP_SLVERR, r);
		axi_rd(8'h24, v, r);
		check_val("rdata_unmapped", 32'h0, v);
		check_val("rresp_unmapped", flash_pkg::RESP_SLVERR, r);
		axi_wr(flash_pkg::REG_CMD, {24'h0, flash_pkg::OP_WRITE_DISABLE}, r);
		v = 32'h1;
		while (v[0] !== 1'b0) axi_rd(flash_pkg::REG_STATUS, v, r);
		check_val("irq_masked", 0, irq);
		axi_rd(flash_pkg::REG_IRQ_STATUS, v, r);
		check_val("irq_status", 1, v);
		axi_wr(flash_pkg::REG_IRQ_MASK, 32'h3, r);
		check_val("irq_unmasked", 1, irq);
		axi_wr(flash_pkg::REG_IRQ_STATUS, 32'h1, r);
		check_val("irq_cleared", 0, irq);
		prog(24'h000010, 1, 0, 1'b1, 32'h0);
		cmd(flash_pkg::OP_WRITE_ENABLE);
		cmd(flash_pkg::OP_WRITE_DISABLE);
		cmd(flash_pkg::OP_WRITE_ENABLE);
		prog(24'h000010, 300, 0, 1'b1, $urandom);
		cmd(flash_pkg::OP_WRITE_ENABLE);
		prog(24'h0001fe, 3, 0, 1'b1, $urandom);
		for (int i = 0; i < 3; i++) begin
			cmd(flash_pkg::OP_WRITE_ENABLE);
			prog(24'h000110 + 64 * i + $urandom_range(0, 15), $urandom_range(1, 30), 0, 1'b1,
				$urandom);
		end
		cmd(flash_pkg::OP_WRITE_ENABLE);
		prog(24'h0001c0, 1, 0, 1'b1, {8'h7f, 24'h0});
		cmd(flash_pkg::OP_WRITE_ENABLE);
		prog(24'h0001c0, 1, 0, 1'b1, 32'hffffffff);
		for (int c = 0; c < 4; c++) begin
			cmd(flash_pkg::OP_WRITE_ENABLE);
			@(posedge clk);
			prot <= (c == 3) ? 4'h2 : 4'h0;
			prog((c == 3) ? 24'h010120 : 24'h000120, (c == 0) ? 0 : 1, (c == 1) ? 3 : 0,
				c != 2, $urandom);
		end
		results();
	end
endmodule // testbench
